// ### src/servo_defines.svh
// Register offsets, field positions, reset values and timing figures of the setpoint servo
`ifndef SERVO_DEFINES_SVH
`define SERVO_DEFINES_SVH

// Register byte offsets
`define A_CTRL      8'h00
`define A_MODE      8'h04
`define A_VCMD      8'h08
`define A_SCALE     8'h0C
`define A_RATE      8'h10
`define A_TONMAX    8'h14
`define A_STAT      8'h18
`define A_VMAX      8'h1C
`define A_CEIL      8'h20
`define A_REF       8'h24

// Field positions
`define CTRL_ON     0
`define CTRL_MLO    1
`define CTRL_MHI    2
`define SERVO_BIT   6
`define BUSY_HI     6
`define BUSY_LO     5
`define ST_PSTAGE   0
`define ST_SSDONE   1
`define ST_SERVO    2
`define RISE_LSB    16

// Reset values
`define CTRL_RST    3'h0
`define MODE_RST    8'h00
`define VCMD_RST    16'h0D21
`define SCALE_UNITY 16'h0100
`define RATE_RST    16'h0064
`define RISE_RST    16'h03E8
`define TONMAX_RST  16'h0000
`define WARN_LO     16'h0000
`define WARN_HI     16'hFFFF

// Percentages of nominal, and their divisor
`define UV_PCT      8'd90
`define MLO_PCT     8'd95
`define MHI_PCT     8'd105
`define OV_PCT      8'd110
`define PCT_DEN     100

// Voltages in microvolts; one code is 297.5 uV, held in tenths of a microvolt
`define LSB_DUV     2975
`define UV2CODE(x)  ((x) * 10 / `LSB_DUV)
`define FB_NOM_UV   400000
`define CEIL_FIX_UV 3750000
`define FB_SPAN_UV  1200000
`define Q_FRAC      8

// Timing
`define CLK_NS      5
`define STEP_NS     100000
`define BUSY_MS     500
`define NS_PER_MS   1000000
`define RISE_SKIP_US 250
`define RATE_SKIP   4000
`define RATE_K      1000

`endif

// ### src/servo_pkg.sv
// Types shared by the setpoint servo modules
package servo_pkg;
	// Rail sequencing states, Gray coded along off, rise, on, fall
	typedef enum logic [1:0] {
		RAIL_OFF  = 2'b00,
		RAIL_RISE = 2'b01,
		RAIL_ON   = 2'b11,
		RAIL_FALL = 2'b10
	} rail_state_t;
endpackage : servo_pkg

// ### src/ramp_if.sv
// Signals between the rail sequencer and the setpoint ramp generator
`timescale 1ns/100ps
`default_nettype none
interface ramp_if;
	logic        tick;      // One pulse per ramp step period
	logic        skip;      // Jump straight to target on the next step
	logic        clear;     // Force the ramp to zero
	logic [15:0] step;      // Codes moved per step
	logic [15:0] target;    // Where the ramp heads
	logic [15:0] value;     // Present ramp value
	logic        at_target; // Ramp has arrived
	modport ctl (output tick, skip, clear, step, target, input value, at_target);
	modport gen (input tick, skip, clear, step, target, output value, at_target);
endinterface : ramp_if
`default_nettype wire

// ### src/setpoint_ramp.sv
// Stepped digital ramp of the regulation target
`timescale 1ns/100ps
`default_nettype none
module setpoint_ramp (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	ramp_if.gen       rif
);
	logic [15:0] value_reg;   // Ramp position
	logic [15:0] value_next;  // Next position
	logic        going_up;    // Target lies above
	logic [15:0] gap;         // Distance left

	assign going_up = rif.target > value_reg;
	assign gap = going_up ? rif.target - value_reg : value_reg - rif.target;
	assign rif.value = value_reg;
	assign rif.at_target = value_reg == rif.target;

	// Move one step per tick, never overshooting the target
	always_comb begin
		value_next = value_reg;
		if (rif.clear) begin
			value_next = '0;
		end else if (rif.tick) begin
			if (rif.skip || gap <= rif.step) begin
				value_next = rif.target;
			end else if (going_up) begin
				value_next = value_reg + rif.step;
			end else begin
				value_next = value_reg - rif.step;
			end
		end
	end

	// Ramp register, frozen while ce is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_reg <= '0;
		end else if (ce) begin
			value_reg <= value_next;
		end
	end
endmodule : setpoint_ramp
`default_nettype wire

// ### src/output_voltage_setpoint_ramp_servo.sv
// Output voltage setpoint control: divider or bus mode, soft ramps, ADC servo, APB registers
//
// Function
// - Divider mode limits: -10, -5, +5, +10 percent
// - Warning limits effectively disabled by default
// - Margin high or low selectable in divider mode
// - Divider mode: rate applies at feedback node
// - Bus mode: rate applies to output itself
// - Scale value never changed while rail runs
// - Scale write: busy recompute, defer voltage commands
// - Read-only maximum from scale, capped by ceiling; fixed and uncapped with FIXED_SCALE
// - Servo steps reference one code per conversion
// - Servo needs bit, soft-start done, no faults
// - Servo waits turn-on limit; zero means immediate
// - Servo bit accepted before or during run
// - Run pin released after init and input good
// - Soft-start ramps target from zero to final
// - Ramp steps at most once per 100 us
// - Skip soft-start at 4 V/ms or rise under 250 us
// - Soft-off ramp on run low or command off
// - Power stage off at end of soft-off
// - fault_off turns phases off at once, no ramp
`include "servo_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module output_voltage_setpoint_ramp_servo #(
	parameter int          STEP_CYCLES = `STEP_NS / `CLK_NS,
	parameter int          BUSY_CYCLES = `BUSY_MS * `NS_PER_MS / `CLK_NS,
	parameter bit          FIXED_SCALE = 1'b0,
	parameter logic [15:0] CEIL_CODE   = 16'h3000
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	input  wire logic        run_in,
	output      logic        run_out,
	output      logic        run_oe_n,
	input  wire logic        init_done,
	input  wire logic        vin_ok,
	input  wire logic        uv_fault,
	input  wire logic        oc_fault,
	input  wire logic        fault_off,
	input  wire logic        adc_valid,
	input  wire logic [15:0] adc_code,
	output var  logic [15:0] error_amplifier_ref,
	output      logic        pstage_en,
	output var  logic [15:0] uv_fault_limit,
	output var  logic [15:0] ov_fault_limit,
	output      logic [15:0] uv_warn_limit,
	output      logic [15:0] ov_warn_limit
);
	////////////////////////////////////////////////////////////////////////////////
	// Constants and helpers

	localparam logic [15:0] FB_NOM_CODE  = 16'(`UV2CODE(`FB_NOM_UV));   // Feedback nominal
	localparam logic [15:0] CEIL_FIXED   = 16'(`UV2CODE(`CEIL_FIX_UV)); // Fixed-scale maximum
	localparam logic [31:0] FB_SPAN_CODE = 32'(`UV2CODE(`FB_SPAN_UV));  // Feedback headroom
	localparam logic [31:0] STEP_LAST    = 32'(STEP_CYCLES - 1);       // Tick counter wrap
	localparam logic [31:0] BUSY_LOAD    = 32'(BUSY_CYCLES);           // Recompute time

	// Percentage of a code value
	function automatic logic [15:0] pct(input logic [15:0] v, input logic [7:0] p);
		pct = 16'((32'(v) * 32'(p)) / `PCT_DEN);
	endfunction : pct

	// Output-domain code to feedback-domain code through the Q8.8 scale
	function automatic logic [15:0] to_ref(input logic [15:0] v, input logic [15:0] s);
		if (s == '0) begin
			to_ref = v;
		end else begin
			to_ref = 16'((32'(v) << `Q_FRAC) / 32'(s));
		end
	endfunction : to_ref

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic        run_s1, run_s2;      // Run pin synchroniser
	logic        vin_s1, vin_s2;      // Input-good synchroniser
	logic [2:0]  ctrl_reg;            // On and margin select
	logic [7:0]  mode_reg;            // servo_mode_config
	logic [15:0] vcmd_reg;            // Output voltage command
	logic [15:0] scale_reg;           // Scale-loop ratio, Q8.8
	logic [15:0] rate_reg;            // Transition rate, mV/ms
	logic [15:0] rise_reg;            // Rise time, us
	logic [15:0] tonmax_reg;          // Turn-on limit, in steps
	logic [31:0] busy_cnt_reg;        // Recompute countdown
	logic        pend_valid_reg;      // Deferred write held
	logic [7:0]  pend_addr_reg;       // Its address
	logic [31:0] pend_data_reg;       // Its data
	logic [31:0] tick_cnt_reg;        // Step period counter
	logic [15:0] ton_cnt_reg;         // Steps since turn-on
	logic signed [15:0] trim_reg;     // Servo correction
	servo_pkg::rail_state_t state_reg, state_next;
	ramp_if rif ();

	////////////////////////////////////////////////////////////////////////////////
	// APB decode

	wire setup    = psel & ~penable;
	wire access   = psel & penable;
	wire a_ctrl   = paddr == `A_CTRL;
	wire a_mode   = paddr == `A_MODE;
	wire a_vcmd   = paddr == `A_VCMD;
	wire a_scale  = paddr == `A_SCALE;
	wire a_rate   = paddr == `A_RATE;
	wire a_tonmax = paddr == `A_TONMAX;
	wire mapped   = a_ctrl | a_mode | a_vcmd | a_scale | a_rate | a_tonmax | paddr == `A_STAT
		| paddr == `A_VMAX | paddr == `A_CEIL | paddr == `A_REF;
	wire busy     = busy_cnt_reg != '0;
	wire vrel     = a_ctrl | a_vcmd | a_rate;                      // Voltage-related writes
	wire stall    = access & pwrite & vrel & busy & pend_valid_reg; // Second deferral waits
	wire wr       = access & pwrite & mapped & ~stall;
	wire defer    = wr & vrel & busy;
	wire direct   = wr & ~defer;
	wire apply    = pend_valid_reg & ~busy;                         // Release after recompute
	wire p_ctrl   = pend_addr_reg == `A_CTRL;
	wire p_vcmd   = pend_addr_reg == `A_VCMD;
	wire p_rate   = pend_addr_reg == `A_RATE;

	assign pready  = ~stall;
	assign pslverr = access & ~mapped;

	////////////////////////////////////////////////////////////////////////////////
	// Setpoint arithmetic

	wire rail_idle = state_reg == servo_pkg::RAIL_OFF;
	wire full_bus  = scale_reg != `SCALE_UNITY;
	wire [31:0] vmax_calc = (32'(scale_reg) * FB_SPAN_CODE) >> `Q_FRAC;
	// Maximum from scale, capped by the absolute ceiling; CEIL_FIXED, uncapped, with FIXED_SCALE
	wire [15:0] vout_max = FIXED_SCALE ? CEIL_FIXED
		: (vmax_calc > 32'(CEIL_CODE)) ? CEIL_CODE : vmax_calc[15:0];
	wire [15:0] vcmd_cl  = vcmd_reg > vout_max ? vout_max : vcmd_reg;
	// Divider mode regulates the feedback nominal, bus mode the command
	wire [15:0] nominal  = full_bus ? vcmd_cl : FB_NOM_CODE;
	wire [15:0] margined = ctrl_reg[`CTRL_MLO] ? pct(nominal, `MLO_PCT)
		: ctrl_reg[`CTRL_MHI] ? pct(nominal, `MHI_PCT) : nominal;
	// Rate per step: mV/ms times 0.1 ms over 297.5 uV
	wire [31:0] step_raw = (32'(rate_reg) * `RATE_K) / `LSB_DUV;
	wire        rate_skip = rate_reg >= 16'(`RATE_SKIP);
	wire        rise_skip = rise_reg < 16'(`RISE_SKIP_US);

	////////////////////////////////////////////////////////////////////////////////
	// Rail sequencing conditions

	wire released = init_done & vin_s2;
	wire want_on  = run_s2 & ctrl_reg[`CTRL_ON] & released & ~busy;
	wire fault_any = fault_off;
	wire tick     = tick_cnt_reg == STEP_LAST;
	wire ss_done  = state_reg == servo_pkg::RAIL_ON;
	wire ton_done = tonmax_reg == '0 || ton_cnt_reg >= tonmax_reg;
	wire servo_on = mode_reg[`SERVO_BIT] & ss_done & ~uv_fault & ~oc_fault & ton_done;
	wire ramp_up  = state_reg == servo_pkg::RAIL_RISE || state_reg == servo_pkg::RAIL_ON;

	assign run_out  = 1'b0;
	assign run_oe_n = released;
	// Phases off at once on a fault, without waiting for the ramp
	assign pstage_en = ~rail_idle & ~fault_any;
	assign uv_warn_limit = `WARN_LO;
	assign ov_warn_limit = `WARN_HI;

	////////////////////////////////////////////////////////////////////////////////
	// Ramp generator control

	// Ramp domain is the feedback node in divider mode, the output in bus mode
	assign rif.tick   = tick;
	assign rif.target = ramp_up ? margined : '0;
	assign rif.step   = step_raw == '0 ? 16'h0001 : step_raw[15:0];
	assign rif.skip   = rate_skip | (state_reg == servo_pkg::RAIL_RISE & rise_skip);
	assign rif.clear  = rail_idle | fault_any;

	setpoint_ramp u_ramp (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.rif     (rif.gen)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Rail state machine

	always_comb begin
		state_next = state_reg;
		if (fault_any) begin
			// Fault drops the rail with no soft-off
			state_next = servo_pkg::RAIL_OFF;
		end else begin
			unique case (state_reg)
				servo_pkg::RAIL_OFF: begin
					if (want_on) begin
						state_next = servo_pkg::RAIL_RISE;
					end
				end
				servo_pkg::RAIL_RISE: begin
					if (!want_on) begin
						state_next = servo_pkg::RAIL_FALL;
					end else if (rif.at_target) begin
						state_next = servo_pkg::RAIL_ON;
					end
				end
				servo_pkg::RAIL_ON: begin
					if (!want_on) begin
						state_next = servo_pkg::RAIL_FALL;
					end
				end
				servo_pkg::RAIL_FALL: begin
					if (want_on) begin
						state_next = servo_pkg::RAIL_RISE;
					end else if (rif.at_target) begin
						// Stage off at ramp end whatever the output does
						state_next = servo_pkg::RAIL_OFF;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_s1 <= 1'b0;
			run_s2 <= 1'b0;
			vin_s1 <= 1'b0;
			vin_s2 <= 1'b0;
		end else if (ce) begin
			run_s1 <= run_in;
			run_s2 <= run_s1;
			vin_s1 <= vin_ok;
			vin_s2 <= vin_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencing registers and step timers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg    <= servo_pkg::RAIL_OFF;
			tick_cnt_reg <= '0;
			ton_cnt_reg  <= '0;
		end else if (ce) begin
			state_reg    <= state_next;
			tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 32'h0000_0001;
			// Turn-on timer runs in whole steps while rising or on
			if (!ramp_up) begin
				ton_cnt_reg <= '0;
			end else if (tick && !ton_done) begin
				ton_cnt_reg <= ton_cnt_reg + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Servo trim: one code per conversion toward the commanded reading

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim_reg <= '0;
		end else if (ce) begin
			if (rail_idle || fault_any) begin
				trim_reg <= '0;
			end else if (adc_valid && servo_on) begin
				if (adc_code < margined) begin
					trim_reg <= trim_reg + 16'sh0001;
				end else if (adc_code > margined) begin
					trim_reg <= trim_reg - 16'sh0001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reference and limit outputs

	wire [15:0] base_ref = full_bus ? to_ref(rif.value, scale_reg) : rif.value;
	wire [15:0] ref_sum  = 16'($signed({1'b0, base_ref}) + 17'(trim_reg));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			error_amplifier_ref <= '0;
			uv_fault_limit      <= '0;
			ov_fault_limit      <= '0;
		end else if (ce) begin
			error_amplifier_ref <= fault_any ? '0 : ref_sum;
			uv_fault_limit      <= pct(nominal, `UV_PCT);
			ov_fault_limit      <= pct(nominal, `OV_PCT);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register writes, control, command and rate ones deferred during scale recompute

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg       <= `CTRL_RST;
			mode_reg       <= `MODE_RST;
			vcmd_reg       <= `VCMD_RST;
			scale_reg      <= `SCALE_UNITY;
			rate_reg       <= `RATE_RST;
			rise_reg       <= `RISE_RST;
			tonmax_reg     <= `TONMAX_RST;
			busy_cnt_reg   <= '0;
			pend_valid_reg <= 1'b0;
			pend_addr_reg  <= '0;
			pend_data_reg  <= '0;
		end else if (ce) begin
			// Held write goes in once recompute ends
			if (apply) begin
				pend_valid_reg <= 1'b0;
				if (p_ctrl) begin
					ctrl_reg <= pend_data_reg[2:0];
				end
				if (p_vcmd) begin
					vcmd_reg <= pend_data_reg[15:0];
				end
				if (p_rate) begin
					rate_reg <= pend_data_reg[15:0];
					rise_reg <= pend_data_reg[31:`RISE_LSB];
				end
			end
			if (defer) begin
				pend_valid_reg <= 1'b1;
				pend_addr_reg  <= paddr;
				pend_data_reg  <= pwdata;
			end
			// Direct writes, later than any applied held write
			if (direct && a_ctrl) begin
				ctrl_reg <= pwdata[2:0];
			end
			if (direct && a_mode) begin
				mode_reg <= pwdata[7:0];
			end
			if (direct && a_vcmd) begin
				vcmd_reg <= pwdata[15:0];
			end
			if (direct && a_rate) begin
				rate_reg <= pwdata[15:0];
				rise_reg <= pwdata[31:`RISE_LSB];
			end
			if (direct && a_tonmax) begin
				tonmax_reg <= pwdata[15:0];
			end
			// Scale only taken with the rail off; starts recompute
			if (direct && a_scale && rail_idle) begin
				scale_reg    <= pwdata[15:0];
				busy_cnt_reg <= BUSY_LOAD;
			end else if (busy) begin
				busy_cnt_reg <= busy_cnt_reg - 32'h0000_0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register reads, captured in the setup phase

	wire [31:0] stat_val = {25'h000_0000, busy, busy, 2'b00, servo_on, ss_done, pstage_en};
	wire [31:0] rd_val =
		a_ctrl   ? {29'h0000_0000, ctrl_reg} :
		a_mode   ? {24'h00_0000, mode_reg} :
		a_vcmd   ? {16'h0000, vcmd_reg} :
		a_scale  ? {16'h0000, scale_reg} :
		a_rate   ? {rise_reg, rate_reg} :
		a_tonmax ? {16'h0000, tonmax_reg} :
		paddr == `A_STAT ? stat_val :
		paddr == `A_VMAX ? {16'h0000, vout_max} :
		paddr == `A_CEIL ? {16'h0000, CEIL_CODE} :
		paddr == `A_REF  ? {16'h0000, error_amplifier_ref} : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (ce && setup) begin
			prdata <= pwrite ? '0 : rd_val;
		end
	end
endmodule : output_voltage_setpoint_ramp_servo
`default_nettype wire

// ### verif/servo_assertions.sv
// Port-level checks of the setpoint servo
`timescale 1ns/100ps
`default_nettype none
module servo_assertions #(
	parameter int STEP_CYCLES = 4
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	input wire logic        init_done,
	input wire logic        fault_off,
	input wire logic        adc_valid,
	input wire logic        run_oe_n,
	input wire logic        pstage_en,
	input wire logic [15:0] error_amplifier_ref,
	input wire logic [15:0] uv_warn_limit,
	input wire logic [15:0] ov_warn_limit
);
	logic [15:0] ref_d; // Reference one cycle back
	logic [15:0] gap;   // Cycles since last ramp move
	logic [1:0]  adc_d; // Readings two cycles back
	logic        flt_d; // Fault seen last cycle
	logic        moved; // Reference changed at last edge
	logic        trim;  // Change came from a trim or a fault
	assign moved = error_amplifier_ref != ref_d;
	assign trim = adc_d[1] || flt_d;
	////////////////////////////////////////////////////////////////
	// Track reference and spacing of ramp moves
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_d <= 16'h0000;
			gap <= 16'hFFFF;
			adc_d <= 2'b00;
			flt_d <= 1'b0;
		end else begin
			ref_d <= error_amplifier_ref;
			adc_d <= {adc_d[0], adc_valid};
			flt_d <= fault_off;
			gap <= (moved && !trim) ? 16'h0000 : ((gap == 16'hFFFF) ? gap : gap + 16'h0001);
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_warn_off; uv_warn_limit == 16'h0000 && ov_warn_limit == 16'hFFFF; endproperty
	a_warn_off: assert property (p_warn_off) else $error("warning limits not parked");
	property p_fault_stage; fault_off |-> !pstage_en; endproperty
	a_fault_stage: assert property (p_fault_stage) else $error("stage on in fault");
	property p_fault_ref; fault_off && ce |=> error_amplifier_ref == 16'h0000; endproperty
	a_fault_ref: assert property (p_fault_ref) else $error("reference kept after fault");
	property p_run_hold; (!init_done)[*2] |-> !run_oe_n; endproperty
	a_run_hold: assert property (p_run_hold) else $error("run pin released early");
	property p_step_gap; moved && !trim |-> gap >= STEP_CYCLES - 1; endproperty
	a_step_gap: assert property (p_step_gap) else $error("ramp stepped too fast");
	property p_off_at_zero; $fell(pstage_en) && !fault_off |-> error_amplifier_ref == 16'h0000; endproperty
	a_off_at_zero: assert property (p_off_at_zero) else $error("stage off before ramp end");
	property p_servo_trim;
		moved && adc_d[1] && !flt_d |-> error_amplifier_ref == ref_d + 16'h0001 || error_amplifier_ref + 16'h0001 == ref_d;
	endproperty
	a_servo_trim: assert property (p_servo_trim) else $error("trim not one code");
	property p_off_zero; (!pstage_en)[*2] |-> error_amplifier_ref == 16'h0000; endproperty
	a_off_zero: assert property (p_off_zero) else $error("reference not zero while off");
endmodule : servo_assertions
`default_nettype wire

// ### verif/servo_adc_model.sv
// Output voltage converter: one reading every eight cycles
`timescale 1ns/100ps
`default_nettype none
module servo_adc_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        en,
	input  wire logic [15:0] lvl,
	output      logic        adc_valid,
	output      logic [15:0] adc_code
);
	logic [2:0] cnt; // Conversion pacing
	// Free-running conversion timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cnt <= 3'h0;
		else cnt <= cnt + 3'h1;
	end
	assign adc_valid = en && cnt == 3'h7;
	// Code churns between readings so stale data never looks valid
	assign adc_code = adc_valid ? lvl : ({13'h0000, cnt} ^ 16'hA5A5);
endmodule : servo_adc_model
`default_nettype wire

// ### verif/output_voltage_setpoint_ramp_servo_tb_top.sv
// Register-level testbench of the setpoint servo
`timescale 1ns/100ps
`default_nettype none
module output_voltage_setpoint_ramp_servo_tb_top;
	localparam int STEP = 4;
	localparam logic [7:0] RA [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
	localparam logic [31:0] RV [6] = '{32'h0, 32'h0, 32'h0000_0D21, 32'h0000_0100, 32'h03E8_0064, 32'h0};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        run_ext, run_in, run_out, run_oe_n, init_done, vin_ok, uv_fault, oc_fault;
	logic        fault_off, adc_valid, adc_en, pstage_en;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, r;
	logic [15:0] adc_code, adc_lvl, error_amplifier_ref, uv_fault_limit, ov_fault_limit, uv_warn_limit, ov_warn_limit;
	int          n_fail, num_checks;
	assign run_in = run_ext & (run_oe_n | run_out); // Open-drain run wire with pull-up
	output_voltage_setpoint_ramp_servo #(.STEP_CYCLES(STEP), .BUSY_CYCLES(20)) i_output_voltage_setpoint_ramp_servo (
		.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.run_in(run_in), .run_out(run_out), .run_oe_n(run_oe_n), .init_done(init_done), .vin_ok(vin_ok),
		.uv_fault(uv_fault), .oc_fault(oc_fault), .fault_off(fault_off), .adc_valid(adc_valid),
		.adc_code(adc_code), .error_amplifier_ref(error_amplifier_ref), .pstage_en(pstage_en),
		.uv_fault_limit(uv_fault_limit), .ov_fault_limit(ov_fault_limit),
		.uv_warn_limit(uv_warn_limit), .ov_warn_limit(ov_warn_limit));
	servo_adc_model i_servo_adc_model (.pclk(pclk), .presetn(presetn), .en(adc_en), .lvl(adc_lvl),
		.adc_valid(adc_valid), .adc_code(adc_code));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////
	// Compare within a tolerance
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g, input int t);
		num_checks++;
		if ($isunknown(g) || g > e + t || g + t < e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	task automatic bad(input string nm);
		n_fail++;
		$display("ERROR %s expected done seen timeout", nm);
		print_verdict();
	endtask : bad
	// One APB transfer, waiting for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 400);
		rd = prdata;
		err = pslverr;
		if (n >= 400) bad("pready");
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e, input int t);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd, t);
	endtask : rdc
	// Poll status until the masked bits match
	task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			apb(1'b0, 8'h18, 32'h0);
			n++;
		end while ((rd & m) !== v && n < 200);
		if ((rd & m) !== v) bad("status");
	endtask : wait_stat
	task automatic wait_pin(input logic v);
		int n;
		n = 0;
		while (pstage_en !== v && n < 2000) begin
			@(negedge pclk);
			n++;
		end
		if (pstage_en !== v) bad("pstage_en");
		@(posedge pclk);
	endtask : wait_pin
	// Count three readings, then let the last trim settle
	task automatic pulses;
		int k;
		int n;
		k = 0;
		n = 0;
		while (k < 3 && n < 200) begin
			@(negedge pclk);
			if (adc_valid === 1'b1) k++;
			n++;
		end
		if (k < 3) bad("adc");
		repeat (2) @(posedge pclk);
	endtask : pulses
	////////////////////////////////////////////////////////////////
	initial begin
		{n_fail, num_checks} = '0;
		{presetn, psel, penable, pwrite, paddr, pwdata, init_done, vin_ok} = '0;
		{uv_fault, oc_fault, fault_off, adc_en, adc_lvl} = '0;
		run_ext = 1'b1;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		foreach (RA[i]) rdc("reset_value", RA[i], RV[i], 0);
		rdc("unmapped", 8'h30, 32'h0, 0);
		chk("slverr", 32'h1, {31'h0, err}, 0);
		chk("uv_warn", 32'h0, {16'h0, uv_warn_limit}, 0);
		chk("ov_warn", 32'h0000_FFFF, {16'h0, ov_warn_limit}, 0);
		chk("uv_limit", 32'h0000_04BA, {16'h0, uv_fault_limit}, 1);
		chk("ov_limit", 32'h0000_05C7, {16'h0, ov_fault_limit}, 1);
		chk("run_held", 32'h0, {31'h0, run_oe_n}, 0);
		init_done <= 1'b1;
		vin_ok <= 1'b1;
		repeat (5) @(negedge pclk);
		chk("run_free", 32'h1, {31'h0, run_oe_n}, 0);
		@(posedge pclk);
		apb(1'b0, 8'h1C, 32'h0);
		r = rd;
		apb(1'b1, 8'h1C, ~r);
		rdc("vmax_ro", 8'h1C, r, 0);
		apb(1'b0, 8'h20, 32'h0);
		chk("vmax_cap", 32'h1, {31'h0, r <= rd}, 0);
		$display("test reset done");
		apb(1'b1, 8'h00, 32'h1);
		wait_stat(32'h2, 32'h2);
		rdc("ref_nominal", 8'h24, 32'h0000_0540, 1);
		apb(1'b1, 8'h00, 32'h5);
		repeat (20 * STEP) @(posedge pclk);
		rdc("margin_high", 8'h24, 32'h0000_0583, 1);
		apb(1'b1, 8'h00, 32'h7);
		repeat (20 * STEP) @(posedge pclk);
		rdc("margin_low", 8'h24, 32'h0000_04FD, 1);
		run_ext <= 1'b0;
		wait_pin(1'b0);
		apb(1'b1, 8'h00, 32'h0);
		run_ext <= 1'b1;
		$display("test divider done");
		apb(1'b1, 8'h0C, 32'h0000_0200);
		apb(1'b0, 8'h18, 32'h0);
		chk("busy", 32'h3, {30'h0, rd[6:5]}, 0);
		apb(1'b1, 8'h08, 32'h0000_0B00);
		apb(1'b1, 8'h08, 32'h0000_0C00);
		wait_stat(32'h60, 32'h0);
		rdc("vcmd_held", 8'h08, 32'h0000_0C00, 0);
		$display("test scale done");
		apb(1'b1, 8'h10, 32'h0000_0FA0);
		apb(1'b1, 8'h14, 32'h0);
		apb(1'b1, 8'h04, 32'h0000_0040);
		apb(1'b1, 8'h00, 32'h1);
		wait_pin(1'b1);
		repeat (STEP) @(posedge pclk);
		apb(1'b0, 8'h24, 32'h0);
		r = rd;
		repeat (2 * STEP) @(posedge pclk);
		rdc("ramp_skipped", 8'h24, r, 0);
		chk("ramp_up", 32'h0000_0600, r, 0);
		wait_stat(32'h4, 32'h4);
		adc_en <= 1'b1;
		pulses();
		adc_en <= 1'b0;
		rdc("servo_up", 8'h24, 32'h0000_0603, 0);
		for (int i = 0; i < 2; i++) begin
			{oc_fault, uv_fault} <= 2'b01 << i;
			@(posedge pclk);
			apb(1'b0, 8'h24, 32'h0);
			r = rd;
			adc_en <= 1'b1;
			pulses();
			adc_en <= 1'b0;
			rdc("servo_blocked", 8'h24, r, 0);
		end
		{oc_fault, uv_fault} <= 2'b00;
		apb(1'b1, 8'h0C, 32'h0000_0300);
		rdc("scale_locked", 8'h0C, 32'h0000_0200, 0);
		fault_off <= 1'b1;
		@(negedge pclk);
		chk("fault_stage", 32'h0, {31'h0, pstage_en}, 0);
		@(posedge pclk);
		fault_off <= 1'b0;
		apb(1'b1, 8'h00, 32'h0);
		wait_pin(1'b0);
		$display("test servo done");
		print_verdict();
	end
endmodule : output_voltage_setpoint_ramp_servo_tb_top
bind output_voltage_setpoint_ramp_servo servo_assertions #(.STEP_CYCLES(STEP_CYCLES)) i_servo_assertions (
	.pclk(pclk), .presetn(presetn), .ce(ce), .init_done(init_done), .fault_off(fault_off),
	.adc_valid(adc_valid), .run_oe_n(run_oe_n), .pstage_en(pstage_en),
	.error_amplifier_ref(error_amplifier_ref), .uv_warn_limit(uv_warn_limit), .ov_warn_limit(ov_warn_limit));
`default_nettype wire
